// *** hw/acrf_top.v ***
// Converter control: clock select, completion flag, wake and result format
`timescale 1ns/10ps
`default_nettype none
`include "acrf_map.vh"

module acrf_top (
   input wire CLOCK,                        // System clock, 100 MHz
   input wire RESET,                        // Synchronous reset, active high
   input wire WB_CYC_I,                     // Wishbone cycle
   input wire WB_STB_I,                     // Wishbone strobe
   input wire WB_WE_I,                      // Wishbone write enable
   input wire [7:0] WB_ADR_I,               // Wishbone byte address
   input wire [3:0] WB_SEL_I,               // Wishbone byte selects
   input wire [31:0] WB_DAT_I,              // Wishbone write data
   output reg [31:0] WB_DAT_O,              // Wishbone read data
   output reg WB_ACK_O,                     // Wishbone acknowledge
   input wire RC_CLK_IN,                    // Internal RC oscillator level
   input wire SLEEP_IN,                     // Core is in sleep
   input wire [11:0] FE_DATA,               // Front end converted code
   output reg CONV_CLK_O,                   // Selected conversion clock
   output reg CONV_START_O,                 // Conversion start pulse
   output reg CONV_BUSY_O,                  // Conversion in progress
   output reg WAKE_O,                       // Wake request to core
   output reg IRQ_O                         // Vectored interrupt request
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg [`ACRF_CTRL_W-1:0] ctrl_sw_r;
   reg [`ACRF_CTRL_W-1:0] ctrl_act_r;
   reg [`ACRF_DIV_W-1:0] div_r;
   reg [15:0] result_r;
   reg sw_res_r;
   reg flag_r;
   reg ie_r;
   reg peripheral_irq_enable_r;
   reg gie_r;
   reg go_pend_r;
   reg busy_r;
   reg [3:0] tick_cnt_r;
   reg rc_s1_r;
   reg rc_s2_r;
   reg rc_s3_r;
   reg rc_lvl_r;
   reg rc_tick_r;

   wire div_clk;
   wire div_tick;
   wire [15:0] fmt_res;
   wire wb_req;
   wire wr;
   wire [15:0] wdat;
   wire done;
   wire start;
   wire act_cs;
   wire act_on;
   wire conv_tick;
   // Bus write strobes, decoded once
   wire wr_ctrl;
   wire wr_div;
   wire wr_res;
   wire wr_irq;
   wire go_wr;
   wire flag_clr;
   wire [1:0] res_lane_we;
   reg [15:0] res_rd;
   reg [31:0] rd_nxt;

   assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   assign wr = wb_req & WB_WE_I;
   assign wdat = WB_DAT_I[15:0];
   assign act_cs = ctrl_act_r[`ACRF_CTRL_CS];
   assign act_on = ctrl_act_r[`ACRF_CTRL_ON];

   // ****************************************************************
   // Bus write decode
   // ****************************************************************
   assign wr_ctrl = wr & WB_SEL_I[0] & (WB_ADR_I == `ACRF_OFS_CTRL);
   assign wr_div = wr & WB_SEL_I[0] & (WB_ADR_I == `ACRF_OFS_DIV);
   assign wr_res = wr & (WB_ADR_I == `ACRF_OFS_RESULT);
   assign wr_irq = wr & WB_SEL_I[0] & (WB_ADR_I == `ACRF_OFS_IRQ);
   assign go_wr = wr_ctrl & wdat[`ACRF_CTRL_GO];
   assign flag_clr = wr_irq & wdat[`ACRF_IRQ_FLAG];

   // Each byte lane of the result pair has its own write strobe
   genvar lane;
   generate
      for (lane = 0; lane < 2; lane = lane + 1) begin : g_res_lane
         assign res_lane_we[lane] = wr_res & WB_SEL_I[lane];
      end
   endgenerate

   // ****************************************************************
   // Clock sources
   // ****************************************************************
   acrf_clkdiv u_div (
      .clk(CLOCK),
      .rst(RESET),
      .div(div_r),
      .conv_clk_r(div_clk),
      .tick_r(div_tick)
   );

   // RC level caught by three stages, accepted when last two agree
   always @(posedge CLOCK) begin
      if (RESET) begin
         rc_s1_r <= 1'b0;
         rc_s2_r <= 1'b0;
         rc_s3_r <= 1'b0;
         rc_lvl_r <= 1'b0;
         rc_tick_r <= 1'b0;
      end else begin
         rc_s1_r <= RC_CLK_IN;
         rc_s2_r <= rc_s1_r;
         rc_s3_r <= rc_s2_r;
         if (rc_s2_r == rc_s3_r)
            rc_lvl_r <= rc_s3_r;
         rc_tick_r <= (rc_s2_r == rc_s3_r) & rc_s3_r & ~rc_lvl_r;
      end
   end

   // System-derived ticks halt in sleep; RC ticks keep running
   assign conv_tick = act_cs ? rc_tick_r : (div_tick & ~SLEEP_IN);

   // ****************************************************************
   // Control shadow and conversion sequence
   // ****************************************************************
   assign start = go_pend_r & act_on & ~busy_r & (~act_cs | rc_tick_r);
   assign done = busy_r & conv_tick & (tick_cnt_r == `ACRF_CONV_TICKS);

   always @(posedge CLOCK) begin
      if (RESET) begin
         ctrl_act_r <= `ACRF_CTRL_RST;
         go_pend_r <= 1'b0;
         busy_r <= 1'b0;
         tick_cnt_r <= 4'h0;
         CONV_START_O <= 1'b0;
         CONV_BUSY_O <= 1'b0;
         CONV_CLK_O <= 1'b0;
      end else begin
         if (!act_cs || rc_tick_r)
            ctrl_act_r <= ctrl_sw_r;
         // GO stays pending until it starts a conversion or the software ON bit is cleared
         if (go_wr)
            go_pend_r <= 1'b1;
         else if (start || !ctrl_sw_r[`ACRF_CTRL_ON])
            go_pend_r <= 1'b0;
         if (start) begin
            busy_r <= 1'b1;
            tick_cnt_r <= 4'h0;
         end else if (done) begin
            busy_r <= 1'b0;
         end else if (busy_r && conv_tick) begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
         end
         CONV_START_O <= start;
         CONV_BUSY_O <= start | (busy_r & ~done);
         CONV_CLK_O <= act_cs ? rc_lvl_r : div_clk;
      end
   end

   // ****************************************************************
   // Result formatting and storage
   // ****************************************************************
   acrf_fmt u_fmt (
      .raw(FE_DATA),
      .ic(ctrl_act_r[`ACRF_CTRL_IC]),
      .fm(ctrl_act_r[`ACRF_CTRL_FM_HI:`ACRF_CTRL_FM_LO]),
      .res(fmt_res)
   );

   always @(posedge CLOCK) begin
      if (RESET) begin
         result_r <= 16'h0000;
         sw_res_r <= 1'b0;
      end else if (done) begin
         result_r <= fmt_res;
         sw_res_r <= 1'b0;
      end else if (|res_lane_we) begin
         if (res_lane_we[0])
            result_r[7:0] <= wdat[7:0];
         if (res_lane_we[1])
            result_r[15:8] <= wdat[15:8];
         sw_res_r <= 1'b1;
      end
   end

   // Software-written value reads shifted in left justified formats
   always @* begin
      res_rd = result_r;
      if (sw_res_r && !ctrl_act_r[`ACRF_CTRL_FM_LO])
         res_rd = result_r << `ACRF_SW_SHIFT;
   end

   // ****************************************************************
   // Completion flag, enables, wake and interrupt
   // ****************************************************************
   // Set beats a software clear in the same cycle
   always @(posedge CLOCK) begin
      if (RESET)
         flag_r <= 1'b0;
      else if (done)
         flag_r <= 1'b1;
      else if (flag_clr)
         flag_r <= 1'b0;
   end

   always @(posedge CLOCK) begin
      if (RESET) begin
         ie_r <= 1'b0;
         peripheral_irq_enable_r <= 1'b0;
         gie_r <= 1'b0;
      end else if (wr_irq) begin
         ie_r <= wdat[`ACRF_IRQ_IE];
         peripheral_irq_enable_r <= wdat[`ACRF_IRQ_PERIPHERAL_IRQ_ENABLE];
         gie_r <= wdat[`ACRF_IRQ_GIE];
      end
   end

   // Wake needs no global enable; vectoring does
   always @(posedge CLOCK) begin
      if (RESET) begin
         WAKE_O <= 1'b0;
         IRQ_O <= 1'b0;
      end else begin
         WAKE_O <= SLEEP_IN & flag_r & ie_r & peripheral_irq_enable_r;
         IRQ_O <= flag_r & ie_r & peripheral_irq_enable_r & gie_r;
      end
   end

   // ****************************************************************
   // Wishbone slave
   // ****************************************************************
   always @* begin
      rd_nxt = 32'h00000000;
      case (WB_ADR_I)
         `ACRF_OFS_CTRL: begin
            rd_nxt[`ACRF_CTRL_W-1:0] = ctrl_sw_r;
            rd_nxt[`ACRF_CTRL_GO] = go_pend_r | busy_r;
         end
         `ACRF_OFS_DIV: rd_nxt[`ACRF_DIV_W-1:0] = div_r;
         `ACRF_OFS_RESULT: rd_nxt[15:0] = res_rd;
         `ACRF_OFS_IRQ: begin
            rd_nxt[`ACRF_IRQ_FLAG] = flag_r;
            rd_nxt[`ACRF_IRQ_IE] = ie_r;
            rd_nxt[`ACRF_IRQ_PERIPHERAL_IRQ_ENABLE] = peripheral_irq_enable_r;
            rd_nxt[`ACRF_IRQ_GIE] = gie_r;
         end
         `ACRF_OFS_STATUS: begin
            rd_nxt[`ACRF_ST_BUSY] = busy_r;
            rd_nxt[`ACRF_ST_CS_ACT] = act_cs;
            rd_nxt[`ACRF_ST_SW_RES] = sw_res_r;
         end
         default: rd_nxt = 32'h00000000;
      endcase
   end

   always @(posedge CLOCK) begin
      if (RESET) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
         ctrl_sw_r <= `ACRF_CTRL_RST;
         div_r <= `ACRF_DIV_RST;
      end else begin
         WB_ACK_O <= wb_req;
         if (wb_req && !WB_WE_I)
            WB_DAT_O <= rd_nxt;
         if (wr && WB_SEL_I[0]) begin
            if (wr_ctrl) begin
               ctrl_sw_r <= wdat[`ACRF_CTRL_W-1:0];
               ctrl_sw_r[`ACRF_CTRL_GO] <= 1'b0;
            end
            if (wr_div)
               div_r <= wdat[`ACRF_DIV_W-1:0];
         end
      end
   end

endmodule // acrf_top
`default_nettype wire

// *** hw/acrf_map.vh ***
// Register map, field positions and counts of the converter control block
`ifndef ACRF_MAP_VH
`define ACRF_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ACRF_OFS_CTRL     8'h00
`define ACRF_OFS_DIV      8'h04
`define ACRF_OFS_RESULT   8'h08
`define ACRF_OFS_IRQ      8'h0C
`define ACRF_OFS_STATUS   8'h10

// ****************************************************************
// Control register fields
// ****************************************************************
`define ACRF_CTRL_ON      0
`define ACRF_CTRL_GO      1
`define ACRF_CTRL_CS      2
`define ACRF_CTRL_IC      3
`define ACRF_CTRL_FM_LO   4
`define ACRF_CTRL_FM_HI   5
`define ACRF_CTRL_W       6
`define ACRF_CTRL_RST     6'h00

// ****************************************************************
// Interrupt flag and enable register fields
// ****************************************************************
`define ACRF_IRQ_FLAG     0
`define ACRF_IRQ_IE       1
`define ACRF_IRQ_PERIPHERAL_IRQ_ENABLE     2
`define ACRF_IRQ_GIE      3

// ****************************************************************
// Status register fields
// ****************************************************************
`define ACRF_ST_BUSY      0
`define ACRF_ST_CS_ACT    1
`define ACRF_ST_SW_RES    2

// ****************************************************************
// Widths, reset values and counts
// ****************************************************************
`define ACRF_DIV_W        6
`define ACRF_DIV_RST      6'h01
`define ACRF_RES_W        12
`define ACRF_CONV_TICKS   4'hE
`define ACRF_SW_SHIFT     3
`define ACRF_TC_MAX       12'h7FE
`define ACRF_TC_MIN       12'h801
`define ACRF_TC_NEG_END   12'h800
`define ACRF_SM_MAX       11'h7FF

`endif

// *** hw/acrf_clkdiv.v ***
// System clock divider for the conversion clock, period 2*(n+1) clocks
`timescale 1ns/10ps
`default_nettype none
`include "acrf_map.vh"

module acrf_clkdiv (
   input wire clk,                          // System clock
   input wire rst,                          // Synchronous reset
   input wire [`ACRF_DIV_W-1:0] div,        // Divider setting n
   output reg conv_clk_r,                   // Divided clock level
   output reg tick_r                        // Pulse on each rising half
);

   reg [`ACRF_DIV_W-1:0] cnt_r;

   always @(posedge clk) begin
      if (rst) begin
         cnt_r <= {`ACRF_DIV_W{1'b0}};
         conv_clk_r <= 1'b0;
         tick_r <= 1'b0;
      end else if (cnt_r >= div) begin
         cnt_r <= {`ACRF_DIV_W{1'b0}};
         conv_clk_r <= ~conv_clk_r;
         tick_r <= ~conv_clk_r;
      end else begin
         cnt_r <= cnt_r + 1'b1;
         tick_r <= 1'b0;
      end
   end

endmodule // acrf_clkdiv
`default_nettype wire

// *** hw/acrf_fmt.v ***
// Result justification and number format for the 12-bit converter
`timescale 1ns/10ps
`default_nettype none
`include "acrf_map.vh"

module acrf_fmt (
   input wire [`ACRF_RES_W-1:0] raw,        // Raw converter code
   input wire ic,                           // Input configuration, 1 differential
   input wire [1:0] fm,                     // Format select
   output reg [15:0] res                    // Formatted result pair
);

   reg [`ACRF_RES_W-1:0] tc;
   reg [10:0] mag;
   reg sgn;

   always @* begin
      tc = raw;
      if (raw == `ACRF_TC_NEG_END)
         tc = `ACRF_TC_MIN;
      else if (raw > `ACRF_TC_MAX && raw < `ACRF_TC_NEG_END)
         tc = `ACRF_TC_MAX;
      sgn = raw[`ACRF_RES_W-1];
      if (raw == `ACRF_TC_NEG_END)
         mag = `ACRF_SM_MAX;
      else if (sgn)
         mag = 11'h000 - raw[10:0];
      else
         mag = raw[10:0];
      if (!ic) begin
         if (!fm[0])
            res = {raw, 4'h0};
         else
            res = {4'h0, raw};
      end else begin
         case (fm)
            2'b00: res = {tc, 4'h0};
            2'b01: res = {{4{tc[`ACRF_RES_W-1]}}, tc};
            2'b10: res = {sgn, mag, 4'h0};
            default: res = {sgn, 4'h0, mag};
         endcase
      end
   end

endmodule // acrf_fmt
`default_nettype wire

// *** bench/acrf_top_sva.sv ***
// Port-level assertions for the converter control block
`timescale 1ns/10ps
`default_nettype none

module acrf_top_sva (
   input wire CLOCK,                 // System clock
   input wire RESET,                 // Synchronous reset
   input wire WB_CYC_I,              // Bus cycle
   input wire WB_STB_I,              // Bus strobe
   input wire WB_WE_I,               // Bus write
   input wire [7:0] WB_ADR_I,        // Bus address
   input wire [31:0] WB_DAT_O,       // Read data
   input wire WB_ACK_O,              // Acknowledge
   input wire SLEEP_IN,              // Core sleeping
   input wire CONV_START_O,          // Start pulse
   input wire CONV_BUSY_O,           // Busy level
   input wire WAKE_O,                // Wake request
   input wire IRQ_O                  // Vector request
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
   ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("request not answered");
   unmapped_zero_a: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h40 |->
      WB_DAT_O == 32'h0) else $error("unmapped read not zero");
   flag_sw_clear_a: assert property ($fell(IRQ_O) |->
      WB_ACK_O || $past(WB_ACK_O) || $past(RESET)) else $error("irq fell without write");
   wake_sleep_a: assert property (WAKE_O |-> $past(SLEEP_IN)) else $error("wake awake");
   wake_vector_a: assert property (IRQ_O && $past(SLEEP_IN) |-> WAKE_O)
      else $error("vector without wake");
   start_pulse_a: assert property (CONV_START_O |=> !CONV_START_O) else $error("long start");
   start_busy_a: assert property (CONV_START_O |-> ##[0:1] CONV_BUSY_O)
      else $error("start without busy");
   busy_hold_a: assert property ($rose(CONV_BUSY_O) |-> CONV_BUSY_O [*8])
      else $error("conversion too short");
   cover property (CONV_START_O);
   cover property (WAKE_O);
   cover property (IRQ_O && WAKE_O);
endmodule // acrf_top_sva

bind acrf_top acrf_top_sva u_sva (.CLOCK(CLOCK), .RESET(RESET), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .SLEEP_IN(SLEEP_IN), .CONV_START_O(CONV_START_O),
   .CONV_BUSY_O(CONV_BUSY_O), .WAKE_O(WAKE_O), .IRQ_O(IRQ_O));
`default_nettype wire

// *** bench/acrf_fe_model.sv ***
// Analog front end model: RC oscillator and converted code
`timescale 1ns/10ps
`default_nettype none

module acrf_fe_model (
   input wire clk,                   // System clock
   input wire busy,                  // Conversion in progress
   input wire [11:0] code,           // Code to deliver
   output logic [11:0] fe_data,      // Converted code
   output logic rc_clk               // RC oscillator
);
   initial rc_clk = 1'b0;
   // Free running, unrelated to system clock
   always #37 rc_clk = ~rc_clk;
   // Code valid only while converting, updated on the system clock
   always @(posedge clk)
      fe_data <= (busy === 1'b1) ? code : ~code;
endmodule // acrf_fe_model
`default_nettype wire

// *** bench/acrf_top_tb.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
`include "acrf_map.vh"

module acrf_top_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, slp = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0, lanes = 4'hF;
   logic [31:0] wdat = 32'h0, rd;
   logic [11:0] code = 12'h000;
   logic [11:0] codes [8] = '{12'hABC, 12'h5A3, 12'h123, 12'hFED, 12'h800, 12'h7FF,
      12'hFFE, 12'h800};
   wire [31:0] dat_o;
   wire [11:0] fe;
   wire ack, rcc, cclk, start, busy, wake, irq;
   int num_errors = 0, check_count = 0, cycles = 0, starts = 0;
   longint t0;

   acrf_top u_dut (.CLOCK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
      .RC_CLK_IN(rcc), .SLEEP_IN(slp), .FE_DATA(fe), .CONV_CLK_O(cclk),
      .CONV_START_O(start), .CONV_BUSY_O(busy), .WAKE_O(wake), .IRQ_O(irq));
   acrf_fe_model u_fe (.clk(clk), .busy(busy), .code(code), .fe_data(fe), .rc_clk(rcc));

   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (start === 1'b1) starts <= starts + 1;
      if (cycles == 40000) begin
         num_errors++;
         end_of_test();
      end
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task end_of_test;
      if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      {cyc, stb, we, sel, adr, wdat} <= {2'b11, w, lanes, a, d};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (k == 50) num_errors++;
      rd = dat_o;
      {cyc, stb} <= 2'b00;
   endtask

   task poll;
      int k;
      k = 0;
      do begin
         wb(1'b0, `ACRF_OFS_CTRL, 32'h0);
         k++;
      end while (rd[`ACRF_CTRL_GO] !== 1'b0 && k < 400);
      if (k == 400) num_errors++;
   endtask

   task conv(input logic [31:0] ctrl, input logic [11:0] c);
      code <= c;
      wb(1'b1, `ACRF_OFS_CTRL, ctrl | 32'h3);
      poll();
   endtask

   function logic [15:0] fmt(input logic ic, input logic [1:0] fm, input logic [11:0] c);
      logic [11:0] t;
      logic [10:0] m;
      t = (c == 12'h800) ? 12'h801 : (c == 12'h7FF) ? 12'h7FE : c;
      m = (c == 12'h800) ? 11'h7FF : c[11] ? 11'(-c) : c[10:0];
      if (!ic) return fm[0] ? {4'h0, c} : {c, 4'h0};
      case (fm)
         2'b00: return {t, 4'h0};
         2'b01: return {{4{t[11]}}, t};
         2'b10: return {c[11], m, 4'h0};
         default: return {c[11], 4'h0, m};
      endcase
   endfunction

   // ****************************************************************
   // Sequence
   // ****************************************************************
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wb(1'b0, `ACRF_OFS_DIV, 32'h0);
      chk(rd, 32'h1);
      wb(1'b1, `ACRF_OFS_DIV, 32'h3);
      repeat (2) @(posedge cclk);
      t0 = $time;
      @(posedge cclk);
      chk(32'($time - t0), 32'd80);
      wb(1'b1, `ACRF_OFS_DIV, 32'h1);
      for (int i = 0; i < 8; i++) begin
         conv(32'({i[1:0], i[2], 3'b000}), codes[i]);
         wb(1'b0, `ACRF_OFS_RESULT, 32'h0);
         chk(rd, {16'h0, fmt(i[2], i[1:0], codes[i])});
         wb(1'b0, `ACRF_OFS_IRQ, 32'h0);
         chk(rd & 32'h1, 32'h1);
         if (i == 0) begin
            repeat (100) @(posedge clk);
            wb(1'b0, `ACRF_OFS_IRQ, 32'h0);
            chk(rd & 32'h1, 32'h1);
         end
         wb(1'b1, `ACRF_OFS_IRQ, 32'h1);
      end
      chk(starts, 32'd8);
      wb(1'b0, `ACRF_OFS_IRQ, 32'h0);
      chk(rd, 32'h0);
      for (int f = 0; f < 4; f++) begin
         wb(1'b1, `ACRF_OFS_CTRL, 32'({f[1:0], 4'h1}));
         wb(1'b1, `ACRF_OFS_RESULT, 32'h0123);
         wb(1'b0, `ACRF_OFS_RESULT, 32'h0);
         chk(rd, f[0] ? 32'h0123 : 32'h0918);
      end
      lanes = 4'h2;
      wb(1'b1, `ACRF_OFS_RESULT, 32'hAB55);
      lanes = 4'hF;
      wb(1'b0, `ACRF_OFS_RESULT, 32'h0);
      chk(rd, 32'hAB23);
      wb(1'b0, `ACRF_OFS_STATUS, 32'h0);
      chk(rd, 32'h4);
      wb(1'b1, `ACRF_OFS_IRQ, 32'h7);
      slp <= 1'b1;
      code <= 12'h2D4;
      wb(1'b1, `ACRF_OFS_CTRL, 32'h13);
      repeat (200) @(posedge clk);
      chk({30'h0, busy, wake}, 32'h2);
      slp <= 1'b0;
      poll();
      wb(1'b1, `ACRF_OFS_IRQ, 32'h7);
      slp <= 1'b1;
      conv(32'h14, 12'h5C7);
      wb(1'b0, `ACRF_OFS_RESULT, 32'h0);
      chk(rd, 32'h05C7);
      wb(1'b0, `ACRF_OFS_STATUS, 32'h0);
      chk(rd, 32'h2);
      repeat (2) @(posedge clk);
      chk({30'h0, wake, irq}, 32'h2);
      wb(1'b1, `ACRF_OFS_IRQ, 32'hE);
      repeat (2) @(posedge clk);
      chk({30'h0, wake, irq}, 32'h3);
      wb(1'b1, `ACRF_OFS_IRQ, 32'hF);
      slp <= 1'b0;
      wb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      end_of_test();
   end
endmodule // acrf_top_tb
`default_nettype wire
